// file: hw/awdt_defines.svh
`ifndef AWDT_DEFINES_SVH
`define AWDT_DEFINES_SVH

// register indices; byte address is four times the index
`define AWDT_IDX_UNIT 8'hF1
`define AWDT_IDX_PERIOD 8'hF2
`define AWDT_IDX_CFG 8'hF3
`define AWDT_IDX_CTRL 8'hF4
`define AWDT_IDX_ISR 8'hF8
`define AWDT_IDX_IMR 8'hF9

// field positions
`define AWDT_UNIT_SEC_BIT 7
`define AWDT_CTRL_STS_BIT 0
`define AWDT_CTRL_FORCE_BIT 2
`define AWDT_CTRL_EDGE_BIT 3
`define AWDT_EVT_TIMEOUT_BIT 0
`define AWDT_EVT_RESTART_BIT 1

// reset values
`define AWDT_RST_BYTE 8'h00
`define AWDT_RST_EVT 2'h0

// interrupt line select codes
`define AWDT_IRQ_NONE 4'h0
`define AWDT_IRQ_INVALID 4'h2

// timing
`define AWDT_CLK_NS 20
`define AWDT_SEC_NS 1000000000
`define AWDT_SEC_PER_MIN 60

// bus answers
`define AWDT_RESP_OKAY 2'h0
`define AWDT_RESP_SLVERR 2'h2

`endif

// file: hw/awdt_pkg.sv
package awdt_pkg;

  typedef struct packed
  {
    logic [3:0] irq_sel;
    logic rsvd;
    logic mouse_en;
    logic kbd_en;
    logic game_en;
  } awdt_cfg_t;

  typedef struct packed
  {
    logic game_access;
    logic kbd_irq;
    logic mouse_irq;
    logic kbc_timeout_pulse;
  } awdt_act_t;

  typedef enum logic [1:0]
  {
    ST_OFF,
    ST_RUN,
    ST_EXPIRED
  } awdt_state_t;

endpackage

// file: hw/awdt_top.sv
// Operation
// - unit bit 7: clear minutes, set seconds
// - period zero disables counting time-outs
// - period N gives N selected units
// - enabled game port access restarts count
// - enabled keyboard interrupt restarts count
// - enabled mouse interrupt restarts count
// - config upper nibble routes interrupt line
// - control bit 0 shows time-out occurred
// - force bit makes time-out, self-clears
// - enabled kbc pulse rising edge forces time-out
// - edge detect pulse ORed with force
// - bus reset clears all but control, standby clears control
`timescale 1ns/100ps
`include "awdt_defines.svh"
module awdt_top #(
  parameter int unsigned SEC_CYCLES = `AWDT_SEC_NS / `AWDT_CLK_NS
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby_supply_por_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire awdt_pkg::awdt_act_t activity,
  output logic [15:0] irq_lines,
  output logic irq
);
  import awdt_pkg::*;

  localparam logic [5:0] MIN_LAST = 6'(`AWDT_SEC_PER_MIN - 1);
  localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);

  function automatic logic reg_hit(
    input logic [11:0] a,
    input logic [7:0] idx
  );
    reg_hit = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic reg_mapped(input logic [11:0] a);
    reg_mapped = reg_hit(a, `AWDT_IDX_UNIT)
      || reg_hit(a, `AWDT_IDX_PERIOD)
      || reg_hit(a, `AWDT_IDX_CFG)
      || reg_hit(a, `AWDT_IDX_CTRL)
      || reg_hit(a, `AWDT_IDX_ISR)
      || reg_hit(a, `AWDT_IDX_IMR);
  endfunction

  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic wr_ok;
  logic [7:0] unit_q;
  logic [7:0] period_q;
  awdt_cfg_t cfg_q;
  logic sts_q;
  logic edge_en_q;
  logic force_q;
  logic [1:0] isr_q;
  logic [1:0] imr_q;
  logic [2:0] kbd_sync_q;
  logic [2:0] mouse_sync_q;
  logic [2:0] kbc_sync_q;
  logic kbd_rise;
  logic mouse_rise;
  logic kbc_rise;
  logic [25:0] sec_cnt_q;
  logic [5:0] min_cnt_q;
  logic [7:0] remain_q;
  awdt_state_t state_q;
  logic sec_tick;
  logic unit_tick;
  logic period_wr;
  logic restart_evt;
  logic reload;
  logic [7:0] load_val;
  logic count_expire;
  logic timeout_evt;
  logic [31:0] rd_word;

  // bus slave: address and data may arrive in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  // lane 0 carries every register; other lanes are ignored
  assign wr_ok = wr_fire && wstrb_q[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `AWDT_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= reg_mapped(awaddr_q) ? `AWDT_RESP_OKAY
                                       : `AWDT_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    if (reg_hit(s_axi_araddr, `AWDT_IDX_UNIT))
      rd_word[`AWDT_UNIT_SEC_BIT] = unit_q[`AWDT_UNIT_SEC_BIT];
    else if (reg_hit(s_axi_araddr, `AWDT_IDX_PERIOD))
      rd_word[7:0] = period_q;
    else if (reg_hit(s_axi_araddr, `AWDT_IDX_CFG))
      rd_word[7:0] = {cfg_q.irq_sel, 1'b0, cfg_q.mouse_en,
                      cfg_q.kbd_en, cfg_q.game_en};
    else if (reg_hit(s_axi_araddr, `AWDT_IDX_CTRL))
    begin
      rd_word[`AWDT_CTRL_STS_BIT] = sts_q;
      rd_word[`AWDT_CTRL_EDGE_BIT] = edge_en_q;
    end
    else if (reg_hit(s_axi_araddr, `AWDT_IDX_ISR))
      rd_word[1:0] = isr_q;
    else if (reg_hit(s_axi_araddr, `AWDT_IDX_IMR))
      rd_word[1:0] = imr_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `AWDT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= reg_mapped(s_axi_araddr) ? `AWDT_RESP_OKAY
                                           : `AWDT_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // host-bus-reset registers
  assign period_wr = wr_ok && reg_hit(awaddr_q, `AWDT_IDX_PERIOD);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_q <= `AWDT_RST_BYTE;
      period_q <= `AWDT_RST_BYTE;
      cfg_q <= `AWDT_RST_BYTE;
    end
    else if (wr_ok)
    begin
      if (reg_hit(awaddr_q, `AWDT_IDX_UNIT))
        unit_q <= {wdata_q[`AWDT_UNIT_SEC_BIT], 7'h00};
      if (period_wr)
        period_q <= wdata_q[7:0];
      if (reg_hit(awaddr_q, `AWDT_IDX_CFG))
        cfg_q <= {wdata_q[7:4], 1'b0, wdata_q[2:0]};
    end
  end

  // control survives bus reset; of the two resets only the standby supply clears it
  always_ff @(posedge aclk)
  begin
    if (!standby_supply_por_n)
    begin
      sts_q <= 1'b0;
      edge_en_q <= 1'b0;
      force_q <= 1'b0;
    end
    else
    begin
      // upper bits dropped, software keeps them zero
      force_q <= wr_ok && reg_hit(awaddr_q, `AWDT_IDX_CTRL)
                 && wdata_q[`AWDT_CTRL_FORCE_BIT];
      if (timeout_evt)
        sts_q <= 1'b1;
      else if (wr_ok && reg_hit(awaddr_q, `AWDT_IDX_CTRL))
        sts_q <= wdata_q[`AWDT_CTRL_STS_BIT];
      if (wr_ok && reg_hit(awaddr_q, `AWDT_IDX_CTRL))
        edge_en_q <= wdata_q[`AWDT_CTRL_EDGE_BIT];
    end
  end

  // keyboard, mouse and kbc inputs come from other logic; synchronise, then edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      kbd_sync_q <= 3'h0;
      mouse_sync_q <= 3'h0;
      kbc_sync_q <= 3'h0;
    end
    else
    begin
      kbd_sync_q <= {kbd_sync_q[1:0], activity.kbd_irq};
      mouse_sync_q <= {mouse_sync_q[1:0], activity.mouse_irq};
      kbc_sync_q <= {kbc_sync_q[1:0], activity.kbc_timeout_pulse};
    end
  end

  assign kbd_rise = kbd_sync_q[1] && !kbd_sync_q[2];
  assign mouse_rise = mouse_sync_q[1] && !mouse_sync_q[2];
  // a long-high pulse yields one event only
  assign kbc_rise = kbc_sync_q[1] && !kbc_sync_q[2];

  assign restart_evt = (cfg_q.game_en && activity.game_access)
    || (cfg_q.kbd_en && kbd_rise)
    || (cfg_q.mouse_en && mouse_rise);
  assign reload = restart_evt || period_wr;
  assign load_val = period_wr ? wdata_q[7:0] : period_q;

  // prescaler: seconds, then minutes unless seconds chosen
  assign sec_tick = (sec_cnt_q == SEC_LAST);
  assign unit_tick = sec_tick
    && (unit_q[`AWDT_UNIT_SEC_BIT] || min_cnt_q == MIN_LAST);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || reload)
    begin
      sec_cnt_q <= 26'h0000000;
      min_cnt_q <= 6'h00;
    end
    else if (sec_tick)
    begin
      sec_cnt_q <= 26'h0000000;
      min_cnt_q <= (min_cnt_q == MIN_LAST) ? 6'h00 : min_cnt_q + 6'h01;
    end
    else
      sec_cnt_q <= sec_cnt_q + 26'h0000001;
  end

  assign count_expire = (state_q == ST_RUN) && unit_tick
    && (remain_q == 8'h01);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_OFF;
      remain_q <= 8'h00;
    end
    else if (reload)
    begin
      remain_q <= load_val;
      state_q <= (load_val == 8'h00) ? ST_OFF : ST_RUN;
    end
    else
    begin
      unique case (state_q)
        ST_OFF:
          state_q <= ST_OFF;
        ST_RUN:
          if (count_expire)
          begin
            remain_q <= 8'h00;
            state_q <= ST_EXPIRED;
          end
          else if (unit_tick)
            remain_q <= remain_q - 8'h01;
        ST_EXPIRED:
          state_q <= ST_EXPIRED;
        default:
          state_q <= ST_OFF;
      endcase
    end
  end

  // software force and edge force merged into one event
  assign timeout_evt = count_expire || force_q
    || (edge_en_q && kbc_rise);

  // sticky events, write one to clear; a new event wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      isr_q <= `AWDT_RST_EVT;
      imr_q <= `AWDT_RST_EVT;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == `AWDT_EVT_TIMEOUT_BIT && timeout_evt)
            || (i == `AWDT_EVT_RESTART_BIT && restart_evt))
          isr_q[i] <= 1'b1;
        else if (wr_ok && reg_hit(awaddr_q, `AWDT_IDX_ISR)
                 && wdata_q[i])
          isr_q[i] <= 1'b0;
      end
      if (wr_ok && reg_hit(awaddr_q, `AWDT_IDX_IMR))
        imr_q <= wdata_q[1:0];
    end
  end

  assign irq = |(isr_q & imr_q);

  // line held while status set; zero and the invalid code drive none
  always_comb
  begin
    irq_lines = 16'h0000;
    if (sts_q && cfg_q.irq_sel != `AWDT_IRQ_NONE
        && cfg_q.irq_sel != `AWDT_IRQ_INVALID)
      irq_lines[cfg_q.irq_sel] = 1'b1;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_unit;
    (state_q == ST_RUN && !reload && sec_tick
     && !unit_q[`AWDT_UNIT_SEC_BIT] && min_cnt_q != MIN_LAST)
    |=> remain_q == $past(remain_q);
  endproperty
  a_unit: assert property (p_unit)
    else $error("minute mode counted on a second tick");

  property p_off;
    period_q == 8'h00 |-> state_q == ST_OFF && !count_expire;
  endproperty
  a_off: assert property (p_off)
    else $error("zero period still counting");

  property p_load;
    (reload && load_val != 8'h00)
    |=> state_q == ST_RUN && remain_q == $past(load_val);
  endproperty
  a_load: assert property (p_load)
    else $error("reload did not load period");

  property p_game;
    (activity.game_access && cfg_q.game_en)
    |=> sec_cnt_q == 26'h0000000 && min_cnt_q == 6'h00;
  endproperty
  a_game: assert property (p_game)
    else $error("game access did not restart");

  property p_kbd;
    (kbd_rise && cfg_q.kbd_en && period_q != 8'h00 && !period_wr)
    |=> remain_q == $past(period_q);
  endproperty
  a_kbd: assert property (p_kbd)
    else $error("keyboard interrupt did not restart");

  property p_mouse;
    (mouse_rise && !cfg_q.mouse_en && !kbd_rise && !period_wr
     && !activity.game_access && state_q == ST_RUN && !sec_tick)
    |=> remain_q == $past(remain_q) && sec_cnt_q != 26'h0000000;
  endproperty
  a_mouse: assert property (p_mouse)
    else $error("disabled mouse interrupt restarted");

  property p_route;
    (!sts_q || cfg_q.irq_sel == `AWDT_IRQ_NONE
     || cfg_q.irq_sel == `AWDT_IRQ_INVALID) |-> irq_lines == 16'h0000;
  endproperty
  a_route: assert property (p_route)
    else $error("interrupt line driven without selection");

  property p_force;
    (wr_ok && reg_hit(awaddr_q, `AWDT_IDX_CTRL)
     && wdata_q[`AWDT_CTRL_FORCE_BIT])
    |=> force_q ##1 (!force_q && sts_q);
  endproperty
  a_force: assert property (p_force)
    else $error("force bit did not pulse once");

  property p_edge;
    (kbc_rise && edge_en_q) |=> sts_q ##1 !kbc_rise;
  endproperty
  a_edge: assert property (p_edge)
    else $error("kbc edge did not force time-out");

  property p_sts;
    count_expire |=> sts_q && isr_q[`AWDT_EVT_TIMEOUT_BIT]
      && state_q == ST_EXPIRED;
  endproperty
  a_sts: assert property (p_sts)
    else $error("expiry did not set status");

  property p_rst;
    @(posedge aclk) disable iff (!standby_supply_por_n)
    !aresetn |=> period_q == 8'h00 && unit_q == 8'h00
      && cfg_q == 8'h00 && state_q == ST_OFF;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bus reset left registers set");

endmodule

// file: verif/awdt_act_model.sv
`timescale 1ns/100ps
module awdt_act_model (
  input wire logic aclk,
  output awdt_pkg::awdt_act_t activity
);
  import awdt_pkg::*;
  initial activity = '0;
  // levels hold until changed; a game access also stays high until driven low
  task automatic drive(input int k, input logic v);
    @(posedge aclk);
    activity[k] <= v;
  endtask
endmodule

// file: verif/tb_auxiliary_watchdog_timer.sv
`timescale 1ns/100ps
`include "awdt_defines.svh"
`define CHK(n, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("MISMATCH %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb_auxiliary_watchdog_timer;
  import awdt_pkg::*;
  // short second keeps a 255 count affordable
  localparam int SEC = 20;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic standby_supply_por_n = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdv;
  logic [15:0] irq_lines;
  awdt_act_t activity;
  int checks = 0;
  int err_total = 0;

  awdt_top #(.SEC_CYCLES(SEC)) u_dut (
    .aclk, .aresetn, .standby_supply_por_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .activity, .irq_lines, .irq
  );
  awdt_act_model u_part (.aclk, .activity);

  always #10 aclk = ~aclk;

  function automatic int period_cyc(input int n, input logic sec);
    return n * (sec ? SEC : 60 * SEC);
  endfunction

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] i);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    rd(i);
    `CHK($sformatf("reg %0h", i), {24'h0, e}, rdv)
  endtask

  // bus and sync latency blur the edge by a few cycles
  task automatic expire(input int t, input int sel);
    int n;
    n = 0;
    while (irq_lines === 16'h0000 && n < t + 5)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK("expiry time", 1'h1, (n > t - 4 && n < t + 4))
    `CHK("irq line", 16'h0001 << sel, irq_lines)
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    err_total++;
    final_report;
  end

  initial
  begin
    logic [7:0] d;
    void'($urandom(90));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    standby_supply_por_n <= 1'h1;
    rchk(`AWDT_IDX_UNIT, 8'h00);
    rchk(`AWDT_IDX_PERIOD, 8'h00);
    rchk(`AWDT_IDX_CFG, 8'h00);
    rchk(`AWDT_IDX_CTRL, 8'h00);
    rd(8'h10);
    `CHK("unmapped resp", `AWDT_RESP_SLVERR, resp)
    wr(8'h10, 8'h55);
    `CHK("unmapped wr resp", `AWDT_RESP_SLVERR, resp)
    wr(`AWDT_IDX_UNIT, 8'hFF);
    `CHK("unit wr resp", `AWDT_RESP_OKAY, resp)
    rchk(`AWDT_IDX_UNIT, 8'h80);
    repeat (8)
    begin
      d = 8'($urandom);
      if (d[7:4] == 4'h2) d[7:4] = 4'h3;
      wr(`AWDT_IDX_CFG, d);
      rchk(`AWDT_IDX_CFG, d & 8'hF7);
    end
    for (int s = 0; s < 16; s++)
    begin
      if (s == 2) continue;
      wr(`AWDT_IDX_CFG, 8'(s << 4));
      wr(`AWDT_IDX_CTRL, 8'h04);
      repeat (3) @(posedge aclk);
      `CHK("routed", (s == 0) ? 16'h0 : 16'h1 << s, irq_lines)
      rchk(`AWDT_IDX_CTRL, 8'h01);
      wr(`AWDT_IDX_CTRL, 8'h00);
    end
    `CHK("irq masked", 1'h0, irq)
    wr(`AWDT_IDX_IMR, 8'h01);
    `CHK("irq unmasked", 1'h1, irq)
    wr(`AWDT_IDX_ISR, 8'h01);
    `CHK("irq cleared", 1'h0, irq)
    wr(`AWDT_IDX_CFG, 8'h30);
    wr(`AWDT_IDX_UNIT, 8'h80);
    for (int k = 0; k < 3; k++)
    begin
      d = (k == 0) ? 8'h01 : (k == 1) ? 8'hFF : 8'($urandom_range(9, 2));
      wr(`AWDT_IDX_PERIOD, d);
      expire(period_cyc(d, 1'h1), 3);
      wr(`AWDT_IDX_CTRL, 8'h00);
    end
    wr(`AWDT_IDX_UNIT, 8'h00);
    wr(`AWDT_IDX_PERIOD, 8'h01);
    expire(period_cyc(1, 1'h0), 3);
    wr(`AWDT_IDX_CTRL, 8'h00);
    wr(`AWDT_IDX_PERIOD, 8'h00);
    repeat (1500) @(posedge aclk);
    `CHK("disabled", 16'h0, irq_lines)
    wr(`AWDT_IDX_UNIT, 8'h80);
    for (int k = 1; k < 4; k++)
      for (int e = 0; e < 2; e++)
      begin
        wr(`AWDT_IDX_CFG, 8'h30 | 8'(e << (3 - k)));
        wr(`AWDT_IDX_PERIOD, 8'h02);
        repeat (25) @(posedge aclk);
        u_part.drive(k, 1'h1);
        u_part.drive(k, 1'h0);
        expire(e ? 2 * SEC + ((k == 3) ? 0 : 3) : 13, 3);
        wr(`AWDT_IDX_CTRL, 8'h00);
      end
    wr(`AWDT_IDX_PERIOD, 8'h00);
    wr(`AWDT_IDX_CTRL, 8'h08);
    u_part.drive(0, 1'h1);
    repeat (6) @(posedge aclk);
    `CHK("kbc edge", 16'h0008, irq_lines)
    wr(`AWDT_IDX_CTRL, 8'h08);
    repeat (10) @(posedge aclk);
    `CHK("kbc level", 16'h0000, irq_lines)
    u_part.drive(0, 1'h0);
    wr(`AWDT_IDX_CTRL, 8'h00);
    u_part.drive(0, 1'h1);
    repeat (6) @(posedge aclk);
    `CHK("kbc off", 16'h0000, irq_lines)
    u_part.drive(0, 1'h0);
    wr(`AWDT_IDX_PERIOD, 8'h05);
    wr(`AWDT_IDX_CTRL, 8'h04);
    repeat (3) @(posedge aclk);
    // bus reset alone must leave the control register alone
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(`AWDT_IDX_UNIT, 8'h00);
    rchk(`AWDT_IDX_PERIOD, 8'h00);
    rchk(`AWDT_IDX_CFG, 8'h00);
    rchk(`AWDT_IDX_CTRL, 8'h01);
    standby_supply_por_n <= 1'h0;
    repeat (2) @(posedge aclk);
    standby_supply_por_n <= 1'h1;
    rchk(`AWDT_IDX_CTRL, 8'h00);
    final_report;
  end
endmodule
